// ===== core/adcc_defines.vh
// Constants for the read-triggered converter control block
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// Register offsets (byte addresses)
`define ADCC_OFS_RESULT   8'h00
`define ADCC_OFS_CLKDIV   8'h04
`define ADCC_OFS_CTRL     8'h08
`define ADCC_OFS_ISTAT    8'h0c
`define ADCC_OFS_IEN      8'h10
`define ADCC_OFS_ICLR     8'h14

// Field positions
`define ADCC_DONE_BIT     31
`define ADCC_DIVSEL_BIT   16
`define ADCC_SIGNED_BIT   0
`define ADCC_EV_DONE      0
`define ADCC_EV_OVERRUN   1

// Reset values
`define ADCC_DIVSEL_RST   1'b0
`define ADCC_SIGNED_RST   1'b0
`define ADCC_IEN_RST      2'h0
`define ADCC_ISTAT_RST    2'h0
`define ADCC_SAMPLE_RST   16'h0000

// Reference divide ratios, minus one, and conversion length
`define ADCC_DIV_LO_M1    4'h3
`define ADCC_DIV_HI_M1    4'hf
`define ADCC_CONV_TICKS   6'h10

`endif

// ===== core/adcc_refdiv.v
// Reference clock edge detector and selectable divider for the conversion engine
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"

module adcc_refdiv (
	// Clock and reset
	input  wire       clk,
	input  wire       reset,
	// Reference and divide select
	input  wire       ref_in,
	input  wire       div_sel,
	// Engine tick, one cycle
	output reg        tick_q
);

	reg       sync1_q;
	reg       sync2_q;
	reg       sync3_q;
	reg [3:0] cnt_q;
	wire [3:0] limit;
	wire       ref_rise;

	assign limit    = div_sel ? `ADCC_DIV_HI_M1 : `ADCC_DIV_LO_M1;
	// Edge taken between second and third stage, first stage feeds only the second
	assign ref_rise = sync2_q & ~sync3_q;

	always @(posedge clk) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			cnt_q   <= 4'h0;
			tick_q  <= 1'b0;
		end else begin
			sync1_q <= ref_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			tick_q  <= 1'b0;
			if (ref_rise) begin
				if (cnt_q >= limit) begin
					cnt_q  <= 4'h0;
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

endmodule // adcc_refdiv
`default_nettype wire

// ===== core/adcc_ctrl.v
// Read-triggered conversion control with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"

module adcc_ctrl (
	// Clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// Register port
	input  wire [7:0]  ADDR,
	input  wire [31:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [31:0] RDATA,
	// Converter front end
	input  wire        REF_CLK,
	input  wire [15:0] ANA_CODE,
	output reg         CONV_BUSY,
	// Interrupt
	output reg         IRQ
);

	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;

	reg        state_q;
	reg [5:0]  tick_cnt_q;
	reg        done_q;
	reg [15:0] sample_q;
	reg        div_sel_q;
	reg        signed_q;
	reg [1:0]  istat_q;
	reg [1:0]  ien_q;
	reg [1:0]  ev_d;
	reg [1:0]  istat_d;
	reg [31:0] rdata_d;

	reg        state_d;
	reg [5:0]  tick_cnt_d;
	reg        done_d;
	reg [15:0] sample_d;
	reg        busy_d;
	reg        irq_d;
	wire       eng_tick;
	wire       rd_result;
	wire       rd_busy;
	wire       wr_clkdiv;
	wire       wr_ctrl;
	wire       wr_ien;
	wire       wr_iclr;
	wire       conv_end;

	////////////////////////////////////////////////////////////////////////
	// Reference is sampled on CLK, so it must run well below CLK/4
	adcc_refdiv adcc_refdiv_inst (
		.clk     (CLK),
		.reset   (RESET),
		.ref_in  (REF_CLK),
		.div_sel (div_sel_q),
		.tick_q  (eng_tick)
	);

	// Offset binary code turned into two's complement by flipping the top bit
	function [15:0] fmt_sample;
		input [15:0] code;
		input        sgn;
		begin
			fmt_sample = sgn ? {~code[15], code[14:0]} : code;
		end
	endfunction

	// Address match, shared by every strobe decode
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// Register strobes
	assign rd_result = RD && hit(ADDR, `ADCC_OFS_RESULT);
	assign rd_busy   = rd_result && (state_q == ST_CONV);
	assign wr_clkdiv = WR && hit(ADDR, `ADCC_OFS_CLKDIV);
	assign wr_ctrl   = WR && hit(ADDR, `ADCC_OFS_CTRL);
	assign wr_ien    = WR && hit(ADDR, `ADCC_OFS_IEN);
	assign wr_iclr   = WR && hit(ADDR, `ADCC_OFS_ICLR);

	// Last tick of the conversion
	assign conv_end  = (state_q == ST_CONV) && eng_tick && (tick_cnt_q == `ADCC_CONV_TICKS - 6'h1);

	////////////////////////////////////////////////////////////////////////
	// Conversion engine, next state
	always @* begin
		state_d    = state_q;
		tick_cnt_d = tick_cnt_q;
		done_d     = done_q;
		sample_d   = sample_q;
		busy_d     = CONV_BUSY;
		case (state_q)
			ST_IDLE: begin
				if (rd_result) begin
					state_d    = ST_CONV;
					tick_cnt_d = 6'h0;
					done_d     = 1'b0;
					busy_d     = 1'b1;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					state_d  = ST_IDLE;
					done_d   = 1'b1;
					busy_d   = 1'b0;
					sample_d = fmt_sample(ANA_CODE, signed_q);
				end else if (eng_tick) begin
					tick_cnt_d = tick_cnt_q + 6'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
				busy_d  = 1'b0;
			end
		endcase
	end

	// Conversion engine, registers
	always @(posedge CLK) begin
		if (RESET) begin
			state_q    <= ST_IDLE;
			tick_cnt_q <= 6'h0;
			done_q     <= 1'b0;
			sample_q   <= `ADCC_SAMPLE_RST;
			CONV_BUSY  <= 1'b0;
		end else begin
			state_q    <= state_d;
			tick_cnt_q <= tick_cnt_d;
			done_q     <= done_d;
			sample_q   <= sample_d;
			CONV_BUSY  <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers and interrupt
	always @* begin
		ev_d = 2'h0;
		ev_d[`ADCC_EV_DONE]    = conv_end;
		// Overrun marks a result read that the busy engine ignored
		ev_d[`ADCC_EV_OVERRUN] = rd_busy;
		istat_d = istat_q;
		if (wr_iclr)
			istat_d = istat_d & ~WDATA[1:0];
		// Set beats a clear in the same cycle
		istat_d = istat_d | ev_d;
		// New status, old enable: an enable write shows one cycle late
		irq_d = |(istat_d & ien_q);
	end

	always @(posedge CLK) begin
		if (RESET) begin
			div_sel_q <= `ADCC_DIVSEL_RST;
			signed_q  <= `ADCC_SIGNED_RST;
			ien_q     <= `ADCC_IEN_RST;
			istat_q   <= `ADCC_ISTAT_RST;
			IRQ       <= 1'b0;
		end else begin
			// A change mid conversion stretches or shrinks that conversion
			if (wr_clkdiv)
				div_sel_q <= WDATA[`ADCC_DIVSEL_BIT];
			if (wr_ctrl)
				signed_q <= WDATA[`ADCC_SIGNED_BIT];
			if (wr_ien)
				ien_q <= WDATA[1:0];
			istat_q <= istat_d;
			IRQ     <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path, answer in the cycle after the strobe
	always @* begin
		rdata_d = 32'h0000_0000;
		case (ADDR)
			`ADCC_OFS_RESULT: begin
				rdata_d[`ADCC_DONE_BIT] = done_q;
				rdata_d[15:0] = sample_q;
			end
			`ADCC_OFS_CLKDIV: rdata_d[`ADCC_DIVSEL_BIT] = div_sel_q;
			`ADCC_OFS_CTRL:   rdata_d[`ADCC_SIGNED_BIT] = signed_q;
			`ADCC_OFS_ISTAT:  rdata_d[1:0] = istat_q;
			`ADCC_OFS_IEN:    rdata_d[1:0] = ien_q;
			default:          rdata_d = 32'h0000_0000;
		endcase
	end

	// Zero between answers, so a polled bus never sees stale data
	always @(posedge CLK) begin
		if (RESET)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rdata_d : 32'h0000_0000;
	end

endmodule // adcc_ctrl
`default_nettype wire

// ===== testbench/adcc_ctrl_props.sv
// Assertion checker for converter control
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_props (
	// Clock and reset
	input wire logic	CLK,
	input wire logic	RESET,
	// Bus and engine
	input wire logic [7:0]	ADDR,
	input wire logic	RD,
	input wire logic [31:0]	RDATA,
	input wire logic	CONV_BUSY
);
	wire	res_rd = RD && ADDR == 8'h00;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// First result read after finish
	sequence conv_end;
		first_match($fell(CONV_BUSY) ##[0:8] res_rd);
	endsequence
	trig_start_a: assert property (res_rd && !CONV_BUSY |=> CONV_BUSY)
		else $error("no start");
	no_start_a: assert property (!res_rd && !CONV_BUSY |=> !CONV_BUSY)
		else $error("stray start");
	rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
		else $error("stray data");
	res_pad_a: assert property (res_rd |=> RDATA[30:16] == 15'h0)
		else $error("upper bits set");
	busy_keep_a: assert property ($rose(CONV_BUSY) |-> CONV_BUSY[*8])
		else $error("cut short");
	busy_done_a: assert property (res_rd && CONV_BUSY ##1 CONV_BUSY |-> !RDATA[31])
		else $error("early done");
	end_done_a: assert property (conv_end |=> RDATA[31])
		else $error("done missing");
endmodule // adcc_ctrl_props
////////
bind adcc_ctrl adcc_ctrl_props adcc_ctrl_props_inst (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
	.RD(RD), .RDATA(RDATA), .CONV_BUSY(CONV_BUSY));
`default_nettype wire

// ===== testbench/adcc_ctrl_bench.sv
// Self-checking bench for converter control
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_bench;
	logic		clk = 0, rst = 1, wr = 0, rd = 0, rck = 0;
	logic [7:0]	a = 0;
	logic [15:0]	code = 0;
	logic [31:0]	wd = 0, rv;
	wire [31:0]	rdat;
	wire		busy, irq;
	int		n_fail = 0, n_tests = 0, cyc = 0, t;
	adcc_ctrl adcc_ctrl_inst (.CLK(clk), .RESET(rst), .ADDR(a), .WDATA(wd), .WR(wr), .RD(rd),
		.RDATA(rdat), .REF_CLK(rck), .ANA_CODE(code), .CONV_BUSY(busy), .IRQ(irq));
	always #2 clk = ~clk;
	// Ref at clk/8, slow enough for the sync
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			rck <= ~rck;
		if (cyc == 20000) begin
			n_fail++;
			final_report;
		end
	end
	////////
	task automatic chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rd_reg(input logic [7:0] ad);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 rv = rdat;
	endtask
	task automatic ick(input logic e);
		@(posedge clk);
		#1 chk({31'h0, irq}, {31'h0, e});
	endtask
	// Polls while busy restart nothing, so the span shows the divider; the poll that sees done starts another
	task automatic conv(input int n, input logic [15:0] c, e);
		@(posedge clk);
		code <= c;
		// settle after an input change, scaled to the bench reference
		repeat (8 * n) @(posedge clk);
		rd_reg(8'h00);
		t = 0;
		// keep polling while the done flag reads zero
		do begin
			rd_reg(8'h00);
			t += 2;
		end while (rv[31] !== 1'b1);
		chk(rv, {16'h8000, e});
		chk(t >= 120 * n && t <= 131 * n, 1);
		while (busy)
			@(posedge clk);
		repeat (8 * n) @(posedge clk);
	endtask
	task final_report;
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		rd_reg(8'h04);
		chk(rv, 0);
		conv(4, 16'h8123, 16'h8123);
		rd_reg(8'h0c);
		chk(rv, 3);
		ick(0);
		wr_reg(8'h10, 1);
		ick(1);
		wr_reg(8'h14, 3);
		ick(0);
		wr_reg(8'h04, 32'h0001_0000);
		conv(16, 16'h7fff, 16'h7fff);
		ick(1);
		wr_reg(8'h08, 1);
		wr_reg(8'h04, 0);
		conv(4, 16'h8001, 16'h0001);
		rd_reg(8'h18);
		chk(rv, 0);
		final_report;
	end
endmodule // adcc_ctrl_bench
`default_nettype wire
